//--- hdl/pts_top.sv
// Register bank and transmit-path steering for PHY power save and test.
// Assumes a classic Wishbone master on the same clock and a transmit path
// whose data and idle indications are synchronous to that clock.
//
// Functional notes
// [RULE1] Auto LPI entry when enabled and idle.
// [RULE2] 80% bypass uses force bit instead.
// [RULE3] 50% bypass uses force bit instead.
// [RULE4] Link pulse delayed threshold times 80ns.
// [RULE5] 80% saving bit enables 80% saving.
// [RULE6] Mode bit selects 10M saving or normal.
// [RULE7] Five-bit threshold delays saving switch-on.
// [RULE8] Three-bit field selects 10M filter.
// [RULE9] 100M bypass sends 100M test data.
// [RULE10] 10M bypass sends 10M test data.
// [RULE11] Software keeps reserved bits at reset.
// [RULE12] Accesses are 16-bit half-words only.
// [RULE13] Page field selects page before access.
// [RULE14] Field changes reach path within cycles.
//
// Chosen here: the Wishbone slave port.
module pts_top
    import pts_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [6:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Transmit path side.
    input  wire logic        tx_data_pending,
    input  wire logic        tx10_idle,
    input  wire logic        link_pulse_req,
    input  wire logic [1:0]  tx100_data_in,
    input  wire logic [4:0]  tx10_data_in,
    output logic             tx_lpi_request,
    output logic             link_pulse_out,
    output logic             saving_on,
    output pts_afe_t         afe_out
);

    localparam logic [10:0] UNIT_NS = 11'(PTS_UNIT_NS);
    localparam logic [10:0] CLK_NS  = 11'(PTS_CLK_NS);
    localparam logic [10:0] LINK_NS = 11'(PTS_UNIT_NS * PTS_LINK_UNITS_PER);

    logic        rst_meta;
    logic        rst_sync_n;
    logic [15:0] energy_efficient_config;
    logic [15:0] ten_meg_power_save_control;
    logic [15:0] transmit_data_test_control;
    logic [15:0] page_select;
    logic [4:0]  page;
    logic        bus_req;
    logic        hit_eee;
    logic        hit_save;
    logic        hit_txdata;
    logic        hit_page;
    logic [15:0] lane_mask;
    logic [15:0] next_read;
    logic        saving_eighty_bypass;
    logic        saving_fifty_bypass;
    logic        saving_eighty_force_value;
    logic        saving_fifty_force_value;
    logic [3:0]  link_pulse_delay_threshold;
    logic        saving_eighty_enable;
    logic        ten_meg_saving_mode;
    logic [4:0]  saving_on_delay_threshold;
    logic        link_busy;
    logic [10:0] link_elapsed;
    logic [10:0] link_target;
    logic [10:0] idle_elapsed;
    logic [10:0] idle_target;
    logic        normal_fifty;
    logic        normal_eighty;

    // Reset is released through two flops so release is clean to clock.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign page       = page_select[PTS_PAGE_LSB +: 5];
    assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit_page   = wb_adr_i[6:2] == PTS_IDX_PAGE;
    // Offset 0x17 holds two registers; the page field picks one.
    assign hit_eee    = wb_adr_i[6:2] == PTS_IDX_SHARED17
                        && page == PTS_PAGE_EEE; // [RULE13]
    assign hit_save   = wb_adr_i[6:2] == PTS_IDX_SHARED17
                        && page == PTS_PAGE_SAVE; // [RULE13]
    assign hit_txdata = wb_adr_i[6:2] == PTS_IDX_TXDATA
                        && page == PTS_PAGE_SAVE; // [RULE13]
    // Only the low half-word lanes carry data; upper lanes are ignored.
    assign lane_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}; // [RULE12]

    // Field views of the stored registers.
    assign saving_eighty_bypass       =
        ten_meg_power_save_control[PTS_BYP80_BIT];
    assign saving_fifty_bypass        =
        ten_meg_power_save_control[PTS_BYP50_BIT];
    assign saving_eighty_force_value  =
        ten_meg_power_save_control[PTS_FORCE80_BIT];
    assign saving_fifty_force_value   =
        ten_meg_power_save_control[PTS_FORCE50_BIT];
    assign link_pulse_delay_threshold =
        ten_meg_power_save_control[PTS_LINK_THR_LSB +: 4];
    assign saving_eighty_enable       =
        ten_meg_power_save_control[PTS_SAVE80_BIT];
    assign ten_meg_saving_mode        =
        ten_meg_power_save_control[PTS_MODE_BIT];
    assign saving_on_delay_threshold  =
        ten_meg_power_save_control[PTS_ON_THR_LSB +: 5];

    // Bus answer: one wait state, then a single-cycle ack.
    always_comb begin
        next_read = 16'h0000;
        if (hit_eee) begin
            next_read = energy_efficient_config;
        end else if (hit_save) begin
            next_read = ten_meg_power_save_control;
        end else if (hit_txdata) begin
            next_read = transmit_data_test_control;
        end else if (hit_page) begin
            next_read = page_select;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? {16'h0000, next_read}
                                               : 32'h0000_0000;
        end
    end

    // Reserved bits are not writable, so they always read at reset value.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            energy_efficient_config    <= PTS_RST_EEE;
            ten_meg_power_save_control <= PTS_RST_SAVE;
            transmit_data_test_control <= PTS_RST_TXDATA;
            page_select                <= PTS_RST_PAGE;
        end else if (clk_en && bus_req && wb_we_i) begin
            if (hit_eee) begin
                energy_efficient_config <= (energy_efficient_config
                    & ~(PTS_WMASK_EEE & lane_mask))
                    | (wb_dat_i[15:0] & PTS_WMASK_EEE & lane_mask);
            end
            if (hit_save) begin
                ten_meg_power_save_control <= (ten_meg_power_save_control
                    & ~(PTS_WMASK_SAVE & lane_mask))
                    | (wb_dat_i[15:0] & PTS_WMASK_SAVE & lane_mask);
            end
            if (hit_txdata) begin
                transmit_data_test_control <= (transmit_data_test_control
                    & ~(PTS_WMASK_TXDATA & lane_mask))
                    | (wb_dat_i[15:0] & PTS_WMASK_TXDATA & lane_mask);
            end
            if (hit_page) begin
                page_select <= (page_select
                    & ~(PTS_WMASK_PAGE & lane_mask))
                    | (wb_dat_i[15:0] & PTS_WMASK_PAGE & lane_mask);
            end
        end
    end

    // Low-power idle request follows the idle state one cycle later.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_lpi_request <= 1'b0;
        end else if (clk_en) begin
            tx_lpi_request <= energy_efficient_config[PTS_EEE_ENABLE_BIT]
                              && !tx_data_pending; // [RULE1]
        end
    end

    // Delays are kept in nanoseconds because the threshold unit is not a
    // whole number of core clocks; the wait rounds up to the next edge.
    assign link_target = 11'(link_pulse_delay_threshold) * LINK_NS; // [RULE4]
    assign idle_target = 11'(saving_on_delay_threshold) * UNIT_NS;  // [RULE7]

    // A request arriving while a pulse is pending is dropped.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            link_busy      <= 1'b0;
            link_elapsed   <= 11'h000;
            link_pulse_out <= 1'b0;
        end else if (clk_en) begin
            link_pulse_out <= 1'b0;
            if (!link_busy) begin
                if (link_pulse_req) begin
                    link_busy    <= 1'b1;
                    link_elapsed <= 11'h000;
                end
            end else if (link_elapsed >= link_target) begin
                link_busy      <= 1'b0;
                link_pulse_out <= 1'b1; // [RULE4]
            end else begin
                link_elapsed <= link_elapsed + CLK_NS;
            end
        end
    end

    // Saving switches on once the 10M path has idled past the threshold.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            idle_elapsed <= 11'h000;
            saving_on    <= 1'b0;
        end else if (clk_en) begin
            if (!ten_meg_saving_mode || !tx10_idle) begin
                idle_elapsed <= 11'h000;
                saving_on    <= 1'b0; // [RULE6]
            end else if (idle_elapsed >= idle_target) begin
                saving_on <= 1'b1; // [RULE7]
            end else begin
                idle_elapsed <= idle_elapsed + CLK_NS;
            end
        end
    end

    assign normal_fifty  = saving_on; // [RULE6]
    assign normal_eighty = saving_on && saving_eighty_enable; // [RULE5]

    // All steering is registered once so a field change lands next cycle; a mode bit change lands a cycle later, through saving_on.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            afe_out <= '0;
        end else if (clk_en) begin
            afe_out.save_eighty <= saving_eighty_bypass
                ? saving_eighty_force_value : normal_eighty; // [RULE2]
            afe_out.save_fifty  <= saving_fifty_bypass
                ? saving_fifty_force_value : normal_fifty; // [RULE3]
            afe_out.ten_meg_filter_select <=
                transmit_data_test_control[PTS_FILTER_LSB +: 3]; // [RULE8]
            afe_out.tx100_data <=
                transmit_data_test_control[PTS_BYP100_DATA_BIT]
                ? transmit_data_test_control[PTS_TEST100_LSB +: 2]
                : tx100_data_in; // [RULE9]
            afe_out.tx10_data <=
                transmit_data_test_control[PTS_BYP10_DATA_BIT]
                ? transmit_data_test_control[PTS_TEST10_LSB +: 5]
                : tx10_data_in; // [RULE10]
        end
    end
    // Every output above is a flop updated each enabled cycle. [RULE14]

endmodule : pts_top

//--- hdl/pts_pkg.sv
// Package for the PHY transmit power-save and test control register bank.
// Assumes a 10 MHz core clock and a classic Wishbone slave on 32-bit data.
package pts_pkg;

    // Register indices and page numbers; the byte address on the bus is four times the index.
    localparam logic [4:0]  PTS_IDX_SHARED17  = 5'h17;
    localparam logic [4:0]  PTS_IDX_TXDATA    = 5'h18;
    localparam logic [4:0]  PTS_IDX_PAGE      = 5'h1f;
    localparam logic [4:0]  PTS_PAGE_EEE      = 5'h01;
    localparam logic [4:0]  PTS_PAGE_SAVE     = 5'h02;

    // Reset values.
    localparam logic [15:0] PTS_RST_EEE       = 16'h0033;
    localparam logic [15:0] PTS_RST_SAVE      = 16'h04c8;
    localparam logic [15:0] PTS_RST_TXDATA    = 16'h1000;
    localparam logic [15:0] PTS_RST_PAGE      = 16'h003c;

    // Writable bits; reserved bits hold their reset value.
    localparam logic [15:0] PTS_WMASK_EEE     = 16'h0008;
    localparam logic [15:0] PTS_WMASK_SAVE    = 16'hffdf;
    localparam logic [15:0] PTS_WMASK_TXDATA  = 16'h73df;
    localparam logic [15:0] PTS_WMASK_PAGE    = 16'h1f00;

    // Field positions.
    localparam int PTS_EEE_ENABLE_BIT   = 3;
    localparam int PTS_BYP80_BIT        = 15;
    localparam int PTS_BYP50_BIT        = 14;
    localparam int PTS_FORCE80_BIT      = 13;
    localparam int PTS_FORCE50_BIT      = 12;
    localparam int PTS_LINK_THR_LSB     = 8;
    localparam int PTS_SAVE80_BIT       = 7;
    localparam int PTS_MODE_BIT         = 6;
    localparam int PTS_ON_THR_LSB       = 0;
    localparam int PTS_FILTER_LSB       = 12;
    localparam int PTS_BYP100_DATA_BIT  = 9;
    localparam int PTS_BYP10_DATA_BIT   = 8;
    localparam int PTS_TEST100_LSB      = 6;
    localparam int PTS_TEST10_LSB       = 0;
    localparam int PTS_PAGE_LSB         = 8;

    // Timing: the saving threshold counts in units of this period, the link threshold in units of two periods.
    localparam int PTS_UNIT_NS          = 40;
    localparam int PTS_CLK_NS           = 100;
    localparam int PTS_LINK_UNITS_PER   = 2;

    // Signals toward the analog transmit front end.
    typedef struct packed {
        logic       save_fifty;
        logic       save_eighty;
        logic [2:0] ten_meg_filter_select;
        logic [1:0] tx100_data;
        logic [4:0] tx10_data;
    } pts_afe_t;

endpackage : pts_pkg

//--- verification/pts_top_chk.sv
// Concurrent checks on the ports of the power-save register bank.
// Assumes the bench spaces link requests further apart than the delay.
module pts_top_chk
    import pts_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Transmit path.
    input wire logic        tx_data_pending,
    input wire logic        tx10_idle,
    input wire logic        link_pulse_req,
    input wire logic        tx_lpi_request,
    input wire logic        link_pulse_out,
    input wire logic        saving_on,
    input wire pts_afe_t    afe_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("request not acknowledged after one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside acknowledge");
    a_lpi_idle: assert property (
        tx_lpi_request |-> !$past(tx_data_pending))
        else $error("low power idle while data pending");
    a_lpi_hold: assert property (
        tx_lpi_request && !tx_data_pending && !wb_ack_o |=> tx_lpi_request)
        else $error("low power idle dropped without cause");
    a_link_bound: assert property (
        link_pulse_req |-> ##[2:14] link_pulse_out)
        else $error("link pulse not sent within the longest delay");
    a_link_single: assert property (
        link_pulse_out |=> !link_pulse_out)
        else $error("link pulse longer than one cycle");
    a_saving_idle: assert property (saving_on |-> $past(tx10_idle))
        else $error("saving active while transmitter busy");
    a_filter_write: assert property (
        $changed(afe_out.ten_meg_filter_select) && $past(rstn, 6)
        |-> $past(wb_ack_o))
        else $error("filter select changed without a write");
endmodule : pts_top_chk

bind pts_top pts_top_chk u_pts_top_chk (.clock, .rstn, .clk_en, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_data_pending, .tx10_idle,
    .link_pulse_req, .tx_lpi_request, .link_pulse_out, .saving_on, .afe_out);

//--- verification/pts_afe_src.sv
// Model of the transmit path that feeds normal data into the block.
// Data changes every cycle, so a stale or stuck lane cannot match.
module pts_afe_src (
    // Clock.
    input  wire logic  clock,
    // Normal data and the copy driven one cycle earlier.
    output logic [1:0] tx100_data_in,
    output logic [4:0] tx10_data_in,
    output logic [6:0] prev
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tx100_data_in = 2'h0;
        tx10_data_in = 5'h0;
        prev = 7'h0;
    end
    always @(posedge clock) begin
        prev <= {tx100_data_in, tx10_data_in};
        tx100_data_in <= tx100_data_in + 2'h1;
        tx10_data_in <= tx10_data_in + 5'h0b;
    end
endmodule : pts_afe_src

//--- verification/tb.sv
// Self-checking bench: Wishbone register access and transmit-path steering.
// Assumes the design answers every bus request before the cycle ceiling.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pts_pkg::*;
    logic        clock, ack, lpi, lout, son;
    logic        rstn = 1'b0, cyc = 1'b0, we = 1'b0, en = 1'b1;
    logic        pend = 1'b1, idle = 1'b0, lreq = 1'b0;
    logic [3:0]  sel = 4'h3;
    logic [6:0]  adr = 7'h0;
    logic [31:0] wdat = 32'h0, dat_o;
    logic [1:0]  d100;
    logic [4:0]  d10;
    logic [6:0]  prev;
    logic [3:0]  thr [3] = '{4'h0, 4'h1, 4'hf};
    pts_afe_t    afe;
    int          err_total = 0, compares = 0, cyc_n = 0, n;

    pts_top u_pts_top (.clock(clock), .rstn(rstn), .clk_en(en),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .tx_data_pending(pend), .tx10_idle(idle), .link_pulse_req(lreq),
        .tx100_data_in(d100), .tx10_data_in(d10), .tx_lpi_request(lpi),
        .link_pulse_out(lout), .saving_on(son), .afe_out(afe));
    pts_afe_src u_pts_afe_src (.clock(clock), .tx100_data_in(d100),
        .tx10_data_in(d10), .prev(prev));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Called just after a rising edge; returns one idle cycle after ack.
    // Only the bench's cycle ceiling ends a wait for the acknowledge.
    task automatic wb(input logic w, input logic [6:0] a,
                      input logic [15:0] d, output logic [15:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = dat_o[15:0];
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask : wb

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] q;
        wb(1'b0, a, 16'h0, q);
        chk(q, e);
    endtask : rd

    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // The whole sequence needs well under a thousand cycles.
    always @(posedge clock) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_total++;
            results();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(7'h7c, PTS_RST_PAGE);
        rd(7'h00, 16'h0000);
        wr(7'h7c, 16'h013c);
        rd(7'h5c, PTS_RST_EEE);
        pend <= 1'b0;
        wr(7'h5c, 16'h003b);
        chk(lpi, 1'b1);
        pend <= 1'b1;
        repeat (2) @(posedge clock);
        chk(lpi, 1'b0);
        wr(7'h7c, 16'h023c);
        rd(7'h5c, PTS_RST_SAVE);
        rd(7'h60, PTS_RST_TXDATA);
        for (int f = 0; f < 8; f++) begin
            wr(7'h60, {1'b0, f[2:0], 12'h000});
            chk(afe.ten_meg_filter_select, f[2:0]);
            chk({afe.tx100_data, afe.tx10_data}, prev);
        end
        wr(7'h60, 16'h1395);
        chk(afe.tx100_data, 2'h2);
        chk(afe.tx10_data, 5'h15);
        for (int f = 0; f < 4; f++) begin
            wr(7'h5c, {2'b11, f[1:0], 12'h4c8});
            chk(afe.save_eighty, f[1]);
            chk(afe.save_fifty, f[0]);
        end
        wr(7'h5c, 16'h34df);
        chk({afe.save_eighty, afe.save_fifty}, 2'b00);
        idle <= 1'b1;
        repeat (8) @(posedge clock);
        chk(son, 1'b0);
        repeat (12) @(posedge clock);
        chk(son, 1'b1);
        chk({afe.save_eighty, afe.save_fifty}, 2'b11);
        wr(7'h5c, 16'h345f);
        chk({afe.save_eighty, afe.save_fifty}, 2'b01);
        wr(7'h5c, 16'h341f);
        chk(son, 1'b0);
        idle <= 1'b0;
        foreach (thr[i]) begin
            wr(7'h5c, {4'h0, thr[i], 8'h08});
            lreq <= 1'b1;
            @(posedge clock);
            lreq <= 1'b0;
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (lout !== 1'b1 && n < 20);
            chk(16'(n), 16'(2 + (thr[i] * 80 + 99) / 100));
            repeat (2) @(posedge clock);
        end
        // With the enable low the idle request must stay frozen.
        en <= 1'b0;
        pend <= 1'b0;
        repeat (3) @(posedge clock);
        chk(lpi, 1'b0);
        en <= 1'b1;
        repeat (2) @(posedge clock);
        chk(lpi, 1'b1);
        results();
    end
endmodule : tb
